// ### src/tsa_core.sv
// Temperature sensor alarm core: serial slave, register set, fault queue and alarm.
// Assumes the converter pulses conv_done on clk with a fresh 9-bit code.
// Behaviour
// RQ1: Serial port is a slave to a master clocking up to 400 kHz.
// RQ2: Three strap pins give the lowest three address bits.
// RQ3: Conversions start from reset without any bus command.
// RQ4: Each conversion result is stored as a 16-bit two's complement word.
// RQ5: Top bit of the stored reading is the sign.
// RQ6: Reading lives in bits 15 to 7; low seven bits read zero.
// RQ7: Readings are 9-bit codes of 0.5 degrees per step.
// RQ8: Reading the temperature never disturbs the running conversion.
// RQ9: Each new reading is compared with both limits and updates the alarm.
// RQ10: Over-limit and return limits are 16-bit read/write registers.
// RQ11: Alarm works in comparator or interrupt mode, chosen by configuration.
// RQ12: Interrupt mode flags the alarm when readings exceed the over-limit.
// RQ13: Comparator mode acts as a thermostat between the two limits.
// RQ14: Two configuration bits set the consecutive fault queue depth.
// RQ15: A polarity bit sets alarm active level, active-low after reset.
// RQ16: Limit registers keep any written value as general storage.
// RQ17: Master reads and writes every user register over the serial port; the code leaves temperature read-only.
// RQ18: Fault field 0,1,2,3 needs 1,2,4,6 readings; resets to 0.
// RQ19: Comparator alarm clears on the first reading below the return limit.
// RQ20: Interrupt alarm clears on any register read, re-arms on low readings.
// RQ21: Shutdown finishes the running conversion then stops; port stays alive.
// RQ22: Limit checks compare the top nine bits as signed numbers.
`timescale 1ns/10ps
`default_nettype none
module tsa_core (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Serial port pins
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  // Address straps
  input  wire logic                 addr_pin_0,
  input  wire logic                 addr_pin_1,
  input  wire logic                 addr_pin_2,
  // Converter
  input  wire logic                 conv_done,
  input  wire logic [8:0]           conv_code,
  output logic                      conv_enable,
  // Alarm pin, open drain
  output logic                      thermal_alert_out_o,
  output logic                      thermal_alert_out_oe,
  // Configuration view
  output tsa_pkg::tsa_cfg_t         cfg_o
);
  import tsa_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK} tsa_state_t;

  // Synchronisers
  logic [1:0] scl_m_q, sda_m_q;
  logic [2:0] strap_m_q, strap_q;
  logic       scl_q, sda_q, scl_p_q, sda_p_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_q   <= 2'h3;
      sda_m_q   <= 2'h3;
      strap_m_q <= 3'h0;
      strap_q   <= 3'h0;
    end else begin
      scl_m_q   <= {scl_m_q[0], scl_i};
      sda_m_q   <= {sda_m_q[0], sda_i};
      strap_m_q <= {addr_pin_2, addr_pin_1, addr_pin_0};
      strap_q   <= strap_m_q;
    end
  end
  assign scl_q = scl_m_q[1];
  assign sda_q = sda_m_q[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_q & ~scl_p_q;
  assign scl_fall  = ~scl_q & scl_p_q;
  assign bus_start = scl_q & scl_p_q & sda_p_q & ~sda_q;
  assign bus_stop  = scl_q & scl_p_q & ~sda_p_q & sda_q;

  // Register set
  tsa_cfg_t     cfg_q, cfg_d;
  logic [15:0]  temp_q, temp_d, over_q, over_d, ret_q, ret_d;
  logic [1:0]   ptr_q, ptr_d;

  function automatic logic [7:0] rd_byte(input logic [1:0] p, input logic lo,
                                         input logic [15:0] t, input tsa_cfg_t c,
                                         input logic [15:0] ov, input logic [15:0] rt);
    logic [15:0] w;
    w = 16'h0000;
    unique case (tsa_ptr_t'(p))
      TSA_PTR_TEMP: w = t;
      TSA_PTR_CFG:  w = {{(16 - TSA_CFG_W){1'b0}}, c};
      TSA_PTR_RET:  w = rt;
      TSA_PTR_OVER: w = ov;
    endcase
    if (tsa_ptr_t'(p) == TSA_PTR_CFG)
      rd_byte = w[7:0];
    else
      rd_byte = lo ? w[7:0] : w[15:8];
  endfunction

  // Serial slave
  tsa_state_t  st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d;
  logic [1:0]  bidx_q, bidx_d;
  logic [7:0]  hi_q, hi_d;
  logic        rw_q, rw_d, lo_q, lo_d, nack_q, nack_d, oe_q, oe_d, read_hit;

  always_comb begin
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; bidx_d = bidx_q; hi_d = hi_q;
    rw_d = rw_q; lo_d = lo_q; nack_d = nack_q; oe_d = oe_q;
    ptr_d = ptr_q; cfg_d = cfg_q; over_d = over_q; ret_d = ret_q;
    read_hit = 1'b0;
    if (bus_stop) begin
      st_d = S_IDLE;
      oe_d = 1'b0;
    end else if (bus_start) begin
      st_d  = S_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE: ;
        S_ADDR, S_WR: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == TSA_BITS_BYTE) begin
            if (st_q == S_ADDR) begin
              if (sh_q[7:1] == {TSA_ADDR_BASE, strap_q}) begin                       // [RQ2]
                rw_d = sh_q[0];
                oe_d = 1'b1;
                st_d = S_ADDR_ACK;
              end else begin
                st_d = S_IDLE;
              end
            end else if (bidx_q == 2'h0 && sh_q[7:2] != 6'h00) begin
              st_d = S_IDLE;
            end else begin
              oe_d   = 1'b1;
              st_d   = S_WR_ACK;
              bidx_d = (bidx_q == TSA_BYTE_LAST) ? bidx_q : bidx_q + 2'h1;
              if (bidx_q == 2'h0)
                ptr_d = sh_q[1:0];
              else if (tsa_ptr_t'(ptr_q) == TSA_PTR_CFG && bidx_q == 2'h1)
                cfg_d = tsa_cfg_t'(sh_q[TSA_CFG_W-1:0]);                               // [RQ17]
              else if (bidx_q == 2'h1)
                hi_d = sh_q;
              else if (bidx_q == 2'h2 && tsa_ptr_t'(ptr_q) == TSA_PTR_OVER)
                over_d = {hi_q, sh_q};                                                 // [RQ10] [RQ16]
              else if (bidx_q == 2'h2 && tsa_ptr_t'(ptr_q) == TSA_PTR_RET)
                ret_d = {hi_q, sh_q};                                                  // [RQ10] [RQ16]
            end
          end
        end
        S_ADDR_ACK, S_WR_ACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (st_q == S_ADDR_ACK && rw_q) begin
              read_hit = 1'b1;                                                         // [RQ20]
              lo_d     = 1'b0;
              sh_d     = rd_byte(ptr_q, 1'b0, temp_q, cfg_q, over_q, ret_q);
              oe_d     = ~sh_d[7];
              st_d     = S_RD;
            end else begin
              if (st_q == S_ADDR_ACK)
                bidx_d = 2'h0;
              oe_d = 1'b0;
              st_d = S_WR;
            end
          end
        end
        S_RD: begin
          if (scl_rise)
            cnt_d = cnt_q + 4'h1;
          else if (scl_fall && cnt_q == TSA_BITS_BYTE) begin
            oe_d = 1'b0;
            st_d = S_RD_ACK;
          end else if (scl_fall) begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = ~sh_d[7];
          end
        end
        S_RD_ACK: begin
          if (scl_rise)
            nack_d = sda_q;
          else if (scl_fall && nack_q)
            st_d = S_IDLE;
          else if (scl_fall) begin
            lo_d  = ~lo_q;
            sh_d  = rd_byte(ptr_q, ~lo_q, temp_q, cfg_q, over_q, ret_q);               // [RQ8]
            oe_d  = ~sh_d[7];
            cnt_d = 4'h0;
            st_d  = S_RD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE; cnt_q <= 4'h0; sh_q <= 8'h00; bidx_q <= 2'h0; hi_q <= 8'h00;
      rw_q <= 1'b0; lo_q <= 1'b0; nack_q <= 1'b0; oe_q <= 1'b0;
      ptr_q <= 2'h0; cfg_q <= tsa_cfg_t'(TSA_CFG_RST);                                 // [RQ15] [RQ18]
      over_q <= TSA_OVER_RST; ret_q <= TSA_RET_RST;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; bidx_q <= bidx_d; hi_q <= hi_d;
      rw_q <= rw_d; lo_q <= lo_d; nack_q <= nack_d; oe_q <= oe_d;
      ptr_q <= ptr_d; cfg_q <= cfg_d; over_q <= over_d; ret_q <= ret_d;
    end
  end

  // Open drain data: only ever pulls low
  assign sda_o  = 1'b0;                                                                // [RQ1]
  assign sda_oe = oe_q;
  assign cfg_o  = cfg_q;

  // Conversion and alarm
  logic        alert_q, alert_d, dir_q, dir_d, pin_oe_q, pin_oe_d;
  logic [2:0]  fcnt_q, fcnt_d;
  logic        over_hit, under_hit, qual;
  assign conv_enable = ~cfg_q.low_power;                                               // [RQ3] [RQ21]
  // Fresh code holds the same bits temp_d stores; avoids a loop through temp_d
  assign over_hit  = $signed(conv_code) > $signed(over_q[TSA_RD_MSB:TSA_RD_LSB]);  // [RQ22]
  assign under_hit = $signed(conv_code) < $signed(ret_q[TSA_RD_MSB:TSA_RD_LSB]);   // [RQ22]
  assign qual      = (cfg_q.irq_mode && dir_q) ? under_hit : over_hit;

  always_comb begin
    temp_d = temp_q; alert_d = alert_q; dir_d = dir_q; fcnt_d = fcnt_q;
    // Clears first so that a same-cycle trip wins
    if (cfg_q.irq_mode && (read_hit || cfg_q.low_power))
      alert_d = 1'b0;                                                                  // [RQ20]
    if (conv_done) begin
      temp_d = {conv_code, {TSA_RD_LSB{1'b0}}};                                        // [RQ4] [RQ5] [RQ6] [RQ7]
      if (!cfg_q.irq_mode && alert_q) begin
        fcnt_d = 3'h0;
        if (under_hit)
          alert_d = 1'b0;                                                              // [RQ13] [RQ19]
      end else if (!qual) begin
        fcnt_d = 3'h0;
      end else if (fcnt_q + 3'h1 >= tsa_fault_need(cfg_q.fault_sel)) begin             // [RQ14] [RQ18]
        fcnt_d  = 3'h0;
        alert_d = 1'b1;                                                                // [RQ9] [RQ12]
        dir_d   = cfg_q.irq_mode ? ~dir_q : 1'b0;
      end else begin
        fcnt_d = fcnt_q + 3'h1;
      end
    end
    pin_oe_d = alert_d ^ cfg_q.active_level;                                           // [RQ11] [RQ15]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_q <= TSA_TEMP_RST; alert_q <= 1'b0; dir_q <= 1'b0; fcnt_q <= 3'h0; pin_oe_q <= 1'b0;
    end else begin
      temp_q <= temp_d; alert_q <= alert_d; dir_q <= dir_d; fcnt_q <= fcnt_d; pin_oe_q <= pin_oe_d;
    end
  end
  assign thermal_alert_out_o  = 1'b0;
  assign thermal_alert_out_oe = pin_oe_q;

  // Checks
  temp_store_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ4]
    conv_done |=> temp_q == {$past(conv_code), 7'h00})
    else $error("reading not stored");
  low_bits_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ6]
    temp_q[6:0] == 7'h00)
    else $error("low reading bits set");
  pin_level_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ15]
    ##1 !thermal_alert_out_oe == (alert_q == $past(cfg_q.active_level)))
    else $error("alarm pin level wrong");
  read_clear_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ20]
    read_hit && cfg_q.irq_mode && !conv_done |=> !alert_q)
    else $error("read did not clear alarm");
  cmp_release_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ19]
    conv_done && !cfg_q.irq_mode && alert_q && under_hit |=> !alert_q)
    else $error("thermostat did not release");
  single_fault_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ18]
    conv_done && cfg_q.fault_sel == 2'h0 && over_hit && !alert_q && !dir_q |=> alert_q)
    else $error("one fault did not trip");
  no_early_trip_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ14]
    $rose(alert_q) |-> $past(fcnt_q) + 3'h1 >= tsa_fault_need($past(cfg_q.fault_sel)))
    else $error("alarm before queue full");
  addr_match_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ2]
    st_q == S_ADDR && st_d == S_ADDR_ACK |-> sh_q[3:1] == strap_q)
    else $error("acked wrong address");
  run_from_reset_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ3]
    $past(!rst_n) |-> conv_enable && !cfg_q.low_power)
    else $error("converter not running after reset");
  limits_kept_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ16]
    st_q != S_WR |=> $stable(over_q) && $stable(ret_q))
    else $error("limit changed without write");

endmodule
`default_nettype wire

// ### src/tsa_pkg.sv
// Shared constants and types of the temperature sensor alarm core.
// Assumes a single 50 MHz clock domain; serial pins are synchronised in the core.
package tsa_pkg;

  // Configuration fields, low bits of the configuration byte
  typedef struct packed {
    logic [1:0] fault_sel;
    logic       active_level;
    logic       irq_mode;
    logic       low_power;
  } tsa_cfg_t;

  typedef enum logic [1:0] {TSA_PTR_TEMP, TSA_PTR_CFG, TSA_PTR_RET, TSA_PTR_OVER} tsa_ptr_t;

  localparam int             TSA_CFG_W     = 5;
  localparam logic [4:0]     TSA_CFG_RST   = 5'h00;
  localparam logic [15:0]    TSA_OVER_RST  = 16'h5000;
  localparam logic [15:0]    TSA_RET_RST   = 16'h4B00;
  localparam logic [15:0]    TSA_TEMP_RST  = 16'h0000;
  localparam logic [3:0]     TSA_ADDR_BASE = 4'h9;
  localparam int             TSA_RD_MSB    = 15;
  localparam int             TSA_RD_LSB    = 7;
  localparam logic [3:0]     TSA_BITS_BYTE = 4'h8;
  localparam logic [1:0]     TSA_BYTE_LAST = 2'h3;
  localparam int             TSA_BUS_KHZ   = 400;
  localparam int             TSA_CLK_KHZ   = 50000;
  localparam int             TSA_SCL_HALF  = TSA_CLK_KHZ / (2 * TSA_BUS_KHZ);

  // Consecutive qualifying readings needed for each fault queue setting
  function automatic logic [2:0] tsa_fault_need(input logic [1:0] sel);
    unique case (sel)
      2'h0: tsa_fault_need = 3'h1;
      2'h1: tsa_fault_need = 3'h2;
      2'h2: tsa_fault_need = 3'h4;
      2'h3: tsa_fault_need = 3'h6;
    endcase
  endfunction

endpackage

// ### testbench/tsa_core_tb.sv
// Self-checking bench of the alarm core: registers, conversions, alarm modes.
// Assumes the bus master model and the converter pulses driven here.
`timescale 1ns/10ps
`default_nettype none
module tsa_core_tb;
  import tsa_pkg::*;
  logic       clk, rst_n, scl, m_oe, sda_oe, sda_o, conv_done, conv_enable, al_o, al_oe, ok;
  logic [8:0] conv_code;
  logic [2:0] strap;
  logic [15:0] v, d;
  tsa_cfg_t   cfg;
  int         errors, checks_done;
  wire logic  sda = !(m_oe | sda_oe);
  tsa_core DUT (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_pin_0(strap[0]), .addr_pin_1(strap[1]), .addr_pin_2(strap[2]), .conv_done(conv_done),
    .conv_code(conv_code), .conv_enable(conv_enable), .thermal_alert_out_o(al_o),
    .thermal_alert_out_oe(al_oe), .cfg_o(cfg));
  tsa_master M (.clk(clk), .sda_dut_oe(sda_oe), .scl(scl), .sda_oe_m(m_oe));
  always #10 clk = ~clk;
  function automatic int need(input int sel);
    int t[4] = '{1, 2, 4, 6};
    return t[sel];
  endfunction
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0, got}, {15'h0, exp});
  endtask
  // Pin level: inactive is high unless the polarity bit is set
  task automatic chk_pin(input logic act, input logic alarm_active_level);
    chk_bit(!al_oe, alarm_active_level ? act : !act);
  endtask
  task automatic wr(input tsa_ptr_t p, input logic [15:0] dd, input int nb);
    M.write_reg({TSA_ADDR_BASE, strap}, {6'h0, p}, dd, nb, ok);
    chk_bit(ok, 1'b1);
  endtask
  task automatic rd(input tsa_ptr_t p, input int nb, input logic [15:0] exp);
    M.read_reg({TSA_ADDR_BASE, strap}, {6'h0, p}, nb, v, ok);
    chk_val(v, exp);
  endtask
  task automatic conv(input logic [8:0] c);
    conv_done <= 1'b1;
    conv_code <= c;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic summarize;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    summarize();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    conv_done = 1'b0;
    conv_code = '0;
    strap = '0;
    void'($urandom(32'h0b4d));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk_bit(conv_enable, 1'b1);
    chk_pin(1'b0, 1'b0);
    chk_bit(sda_oe, 1'b0);
    chk_bit(sda_o, 1'b0);
    chk_bit(al_o, 1'b0);
    rd(TSA_PTR_TEMP, 2, TSA_TEMP_RST);
    rd(TSA_PTR_CFG, 1, 16'h0000);
    rd(TSA_PTR_OVER, 2, TSA_OVER_RST);
    rd(TSA_PTR_RET, 2, TSA_RET_RST);
    for (int i = 0; i < 4; i++) begin
      strap <= 3'($urandom);
      repeat (4) @(posedge clk);
      d = 16'($urandom);
      wr(TSA_PTR_OVER, d, 2);
      rd(TSA_PTR_OVER, 2, d);
      M.write_reg({TSA_ADDR_BASE, ~strap}, {6'h0, TSA_PTR_OVER}, ~d, 2, ok);
      chk_bit(ok, 1'b0);
      wr(TSA_PTR_RET, ~d, 2);
      rd(TSA_PTR_RET, 2, ~d);
      rd(TSA_PTR_OVER, 2, d);
    end
    for (int i = 0; i < 12; i++) begin
      d[8:0] = (i < 4) ? 9'(i * 9'h0CE) : 9'($urandom);
      conv(d[8:0]);
      rd(TSA_PTR_TEMP, 2, {d[8:0], 7'h00});
    end
    wr(TSA_PTR_OVER, {9'd100, 7'($urandom)}, 2);
    wr(TSA_PTR_RET, {9'd80, 7'($urandom)}, 2);
    for (int sel = 0; sel < 4; sel++) begin
      wr(TSA_PTR_CFG, {3'h0, 2'(sel), 3'h0, 8'h00}, 1);
      conv(9'd50);
      for (int k = 1; k < need(sel); k++) begin
        conv(9'd120);
      end
      chk_pin(1'b0, 1'b0);
      conv(9'd120);
      chk_pin(1'b1, 1'b0);
      conv(9'd90);
      chk_pin(1'b1, 1'b0);
      conv(9'h1F0);
      chk_pin(1'b0, 1'b0);
    end
    wr(TSA_PTR_CFG, 16'h0400, 1);
    chk_pin(1'b0, 1'b1);
    conv(9'd120);
    chk_pin(1'b1, 1'b1);
    conv(9'd50);
    wr(TSA_PTR_CFG, 16'h0200, 1);
    chk_pin(1'b0, 1'b0);
    conv(9'd120);
    chk_pin(1'b1, 1'b0);
    rd(TSA_PTR_TEMP, 2, 16'h3C00);
    chk_pin(1'b0, 1'b0);
    conv(9'd120);
    chk_pin(1'b0, 1'b0);
    conv(9'd50);
    chk_pin(1'b1, 1'b0);
    rd(TSA_PTR_CFG, 1, 16'h0002);
    chk_pin(1'b0, 1'b0);
    conv(9'd120);
    chk_pin(1'b1, 1'b0);
    wr(TSA_PTR_CFG, 16'h0300, 1);
    chk_pin(1'b0, 1'b0);
    wr(TSA_PTR_CFG, 16'h0100, 1);
    chk_bit(conv_enable, 1'b0);
    chk_val({11'h0, cfg}, 16'h0001);
    conv(9'h033);
    rd(TSA_PTR_TEMP, 2, 16'h1980);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk_val({11'h0, cfg}, {11'h0, TSA_CFG_RST});
    chk_bit(conv_enable, 1'b1);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(TSA_PTR_OVER, 2, TSA_OVER_RST);
    rd(TSA_PTR_TEMP, 2, TSA_TEMP_RST);
    wr(TSA_PTR_CFG, 16'h0000, 1);
    chk_bit(conv_enable, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire

// ### testbench/tsa_master.sv
// Serial bus master model facing the alarm core's 2-wire port.
// Assumes a pull-up on SDA; SCL rests high between frames.
`timescale 1ns/10ps
`default_nettype none
module tsa_master (
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda_dut_oe,
  output logic      scl,
  output logic      sda_oe_m
);
  localparam int HALF = 4;  // Four clocks per SCL phase, 160 ns SCL period
  wire logic sda = !(sda_oe_m | sda_dut_oe);
  initial begin
    scl      = 1'b1;
    sda_oe_m = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data set mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    tick(HALF / 2);
    sda_oe_m <= !b;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF / 2);
    r = sda;
    tick(HALF / 2);
  endtask
  // Released pulse first, so it also serves as repeated start
  task automatic start_cond;
    logic r;
    bit_io(1'b1, r);
    sda_oe_m <= 1'b1;
    tick(HALF);
  endtask
  task automatic stop_cond;
    scl <= 1'b0;
    tick(HALF / 2);
    sda_oe_m <= 1'b1;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF / 2);
    sda_oe_m <= 1'b0;
    tick(HALF);
  endtask
  // Eight bits MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ack_rel, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_rel, r);
  endtask
  task automatic addr_ptr(input logic [6:0] a, input logic [7:0] p, output logic ok);
    logic [7:0] q;
    logic       r;
    start_cond();
    xfer({a, 1'b0}, 1'b1, q, r);
    ok = !r;
    xfer(p, 1'b1, q, r);
    ok &= !r;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, input int nb,
                           output logic ok);
    logic [7:0] q;
    logic       r;
    addr_ptr(a, p, ok);
    for (int k = 0; k < nb; k++) begin
      xfer(d[15 - 8 * k -: 8], 1'b1, q, r);
      ok &= !r;
    end
    stop_cond();
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, input int nb, output logic [15:0] v,
                          output logic ok);
    logic [7:0] q;
    logic       r;
    addr_ptr(a, p, ok);
    start_cond();
    xfer({a, 1'b1}, 1'b1, q, r);
    ok &= !r;
    v = '0;
    for (int k = 0; k < nb; k++) begin
      xfer(8'hFF, k == nb - 1, q, r);
      v = {v[7:0], q};
    end
    stop_cond();
  endtask
endmodule
`default_nettype wire
